// [pkg/ext_decode_defines.svh]
// Functional notes
// - Indexed move: frame pointer plus 7-bit offsets, 12-bit space.
// - Indexed move never writes program counter low or stack top bytes.
// - Indexed move source on an indirect register reads as 00h.
// - Indexed move destination on an indirect register writes nothing.
// - Push literal writes at frame pointer, then decrements it, one cycle.
// - Subtract 6-bit literal from pointer 0, 1 or 2; no flags.
// - The extension enable also turns on indexed offset addressing.
// - Extension off: access bit 0 is access bank, 1 is banked.
// - Extension on, access bit 0, operand to 5Fh: frame pointer offset.
// - Offset mapping serves all byte and bit ops with an access bit.
// - Frame pointer zero makes offsets land on the old access locations.
// - Destination-select bit keeps its meaning in indexed offset mode.
// - One configuration bit, set to 1, enables the extension.
`ifndef EXT_DECODE_DEFINES_SVH
`define EXT_DECODE_DEFINES_SVH

// -----------------------------------------------------------------
// Register map (APB byte addresses)
// -----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_FRAME_PTR 8'h04
`define REG_PTR0 8'h08
`define REG_PTR1 8'h0C
`define REG_BANK 8'h10
`define REG_STATUS 8'h14
`define CTRL_EXT_BIT 0
`define CTRL_RESET 1'h1
`define BANK_RESET 4'h0

// -----------------------------------------------------------------
// Opcode patterns
// -----------------------------------------------------------------
`define OPC_MOVE_HI 9'h1D7
`define OPC_PUSH_HI 8'hEA
`define OPC_SUB_HI 8'hE9
`define SEL_FRAME 2'h3
`define FRAME_IDX 2'h2

// -----------------------------------------------------------------
// Special data addresses
// -----------------------------------------------------------------
`define OFFSET_LIMIT 8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define ACCESS_LOW_BANK 4'h0
`define ADDR_PCL 12'hFF9
`define ADDR_TOS_U 12'hFFF
`define ADDR_TOS_H 12'hFFE
`define ADDR_TOS_L 12'hFFD
`define INDIR0_BASE 12'hFEB
`define INDIR1_BASE 12'hFE3
`define INDIR2_BASE 12'hFDB
`define INDIR_SPAN 12'h005

`endif

// [pkg/ext_decode_pkg.sv]
package ext_decode_pkg;

    typedef enum logic [1:0] {S_RUN, S_MOVE_DEST, S_RET_NOP} state_t;

    typedef enum logic [2:0] {
        OP_NONE, OP_MOVE, OP_PUSH, OP_SUB, OP_SUBRET
    } op_t;

    typedef struct packed {
        logic re;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] f;
        logic a;
        logic d;
    } std_operand_t;

    typedef struct packed {
        logic valid;
        logic [11:0] addr;
        logic to_wreg;
    } std_target_t;

endpackage : ext_decode_pkg

// [design/pointer_file.sv]
`timescale 1ns/1ps
module pointer_file (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Write port
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [11:0] wr_data,
    // Registered pointers
    output logic [2:0][11:0] ptr_q
);
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ptr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ptr_q[gi] <= 12'h000;
                end else if (wr_en && wr_sel == 2'(gi)) begin
                    ptr_q[gi] <= wr_data;
                end
            end
        end
    endgenerate
endmodule : pointer_file

// [design/operand_map.sv]
`timescale 1ns/1ps
`include "ext_decode_defines.svh"
module operand_map (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Mode and pointers
    input wire logic ext_en,
    input wire logic [11:0] frame_ptr,
    input wire logic [3:0] bank_sel,
    // Operand in, effective address out
    input wire ext_decode_pkg::std_operand_t op,
    output ext_decode_pkg::std_target_t target_q
);
    import ext_decode_pkg::*;

    wire indexed = ext_en && !op.a && op.f <= `OFFSET_LIMIT;
    wire [11:0] idx_addr = frame_ptr + {4'h0, op.f};
    wire [3:0] acc_bank = (op.f <= `OFFSET_LIMIT) ? `ACCESS_LOW_BANK
                                                : `ACCESS_HIGH_BANK;
    wire [11:0] lit_addr = op.a ? {bank_sel, op.f}
                                : {acc_bank, op.f};
    std_target_t target_d;

    // Every access-bit instruction the core flags goes through here
    always_comb begin
        target_d.valid = op.valid;
        target_d.addr = indexed ? idx_addr : lit_addr;
        target_d.to_wreg = !op.d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_q <= '0;
        end else begin
            target_q <= target_d;
        end
    end

    property p_map_indexed;
        @(posedge pclk) disable iff (!presetn)
        op.valid && ext_en && !op.a && op.f <= `OFFSET_LIMIT
            |=> target_q.addr == $past(frame_ptr) + {4'h0, $past(op.f)};
    endproperty
    a_map_indexed: assert property (p_map_indexed)
        else $error("indexed operand not offset from frame pointer");

    property p_map_banked;
        @(posedge pclk) disable iff (!presetn)
        op.valid && op.a |=> target_q.addr == {$past(bank_sel), $past(op.f)};
    endproperty
    a_map_banked: assert property (p_map_banked)
        else $error("banked operand mapped wrongly");

    property p_map_legacy;
        @(posedge pclk) disable iff (!presetn)
        op.valid && !ext_en && !op.a && op.f <= `OFFSET_LIMIT
            |=> target_q.addr == {4'h0, $past(op.f)};
    endproperty
    a_map_legacy: assert property (p_map_legacy)
        else $error("legacy access operand mapped wrongly");

    property p_map_dest;
        @(posedge pclk) disable iff (!presetn)
        op.valid |=> target_q.valid && target_q.to_wreg == !$past(op.d);
    endproperty
    a_map_dest: assert property (p_map_dest)
        else $error("destination select altered");
endmodule : operand_map

// [design/ext_stack_decode.sv]
`timescale 1ns/1ps
`include "ext_decode_defines.svh"
module ext_stack_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program words from the fetch stage
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    // Data memory
    output ext_decode_pkg::mem_req_t mem_req,
    input wire logic [7:0] mem_rdata,
    // Return stack and program counter
    input wire logic [20:0] stack_top_value,
    output logic pc_load,
    output logic [20:0] pc_load_value,
    // Standard byte and bit instruction operands
    input wire ext_decode_pkg::std_operand_t std_op,
    output ext_decode_pkg::std_target_t std_target
);
    import ext_decode_pkg::*;

    // -----------------------------------------------------------------
    // Decode helpers
    // -----------------------------------------------------------------
    function automatic op_t op_class(input logic [15:0] w);
        if (w[15:7] == `OPC_MOVE_HI) begin
            return OP_MOVE;
        end else if (w[15:8] == `OPC_PUSH_HI) begin
            return OP_PUSH;
        end else if (w[15:8] == `OPC_SUB_HI) begin
            return (w[7:6] == `SEL_FRAME) ? OP_SUBRET : OP_SUB;
        end
        return OP_NONE;
    endfunction : op_class

    function automatic logic is_indirect(input logic [11:0] a);
        return (a >= `INDIR0_BASE && a < `INDIR0_BASE + `INDIR_SPAN)
            || (a >= `INDIR1_BASE && a < `INDIR1_BASE + `INDIR_SPAN)
            || (a >= `INDIR2_BASE && a < `INDIR2_BASE + `INDIR_SPAN);
    endfunction : is_indirect

    function automatic logic is_protected(input logic [11:0] a);
        return a == `ADDR_PCL || a == `ADDR_TOS_U
            || a == `ADDR_TOS_H || a == `ADDR_TOS_L;
    endfunction : is_protected

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    state_t state_q, state_d;
    logic ext_en_q;
    logic [3:0] bank_q;
    logic rd_pend_q;
    logic [7:0] hold_q;
    logic src_ind_q;
    logic move_nop_q;
    logic [2:0][11:0] ptr;
    mem_req_t mem_req_d;

    wire [11:0] frame_ptr = ptr[`FRAME_IDX];
    wire accept = instr_valid && instr_ready;
    wire in_run = state_q == S_RUN;
    // Extended opcodes only exist while the enable bit is set
    wire op_t op = ext_en_q ? op_class(instr_word) : OP_NONE;
    wire run_acc = accept && in_run;
    wire [11:0] off_addr = frame_ptr + {5'h00, instr_word[6:0]};
    wire src_ind = is_indirect(off_addr);
    wire dst_block = is_indirect(off_addr)
                  || is_protected(off_addr);
    wire [7:0] src_data = src_ind_q ? 8'h00
                        : (rd_pend_q ? mem_rdata : hold_q);
    wire [1:0] sub_sel = instr_word[7:6];
    wire [11:0] k6 = {6'h00, instr_word[5:0]};

    // -----------------------------------------------------------------
    // Pointer updates
    // -----------------------------------------------------------------
    wire ptr_we = run_acc && (op == OP_PUSH || op == OP_SUB
                           || op == OP_SUBRET);
    wire [1:0] ptr_sel = (op == OP_SUB) ? sub_sel : `FRAME_IDX;
    wire [11:0] ptr_wdata = (op == OP_PUSH) ? frame_ptr - 12'h001
                          : ptr[ptr_sel] - k6;

    pointer_file u_ptrs (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(ptr_we),
        .wr_sel(ptr_sel),
        .wr_data(ptr_wdata),
        .ptr_q(ptr)
    );

    operand_map u_map (
        .pclk(pclk),
        .presetn(presetn),
        .ext_en(ext_en_q),
        .frame_ptr(frame_ptr),
        .bank_sel(bank_q),
        .op(std_op),
        .target_q(std_target)
    );

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_RUN: begin
                if (run_acc && op == OP_MOVE) begin
                    state_d = S_MOVE_DEST;
                end else if (run_acc && op == OP_SUBRET) begin
                    state_d = S_RET_NOP;
                end
            end
            S_MOVE_DEST: begin
                if (accept) begin
                    state_d = S_RUN;
                end
            end
            S_RET_NOP: begin
                state_d = S_RUN;
            end
        endcase
    end

    // Memory request: move reads source on word one and writes on word two; push writes on its one word
    always_comb begin
        mem_req_d = '0;
        mem_req_d.addr = mem_req.addr;
        if (run_acc && op == OP_MOVE) begin
            mem_req_d.re = !src_ind;
            mem_req_d.addr = off_addr;
        end else if (run_acc && op == OP_PUSH) begin
            mem_req_d.we = 1'b1;
            mem_req_d.addr = frame_ptr;
            mem_req_d.wdata = instr_word[7:0];
        end else if (accept && state_q == S_MOVE_DEST) begin
            mem_req_d.we = !dst_block;
            mem_req_d.addr = off_addr;
            mem_req_d.wdata = src_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_RUN;
            instr_ready <= 1'b1;
            mem_req <= '0;
        end else begin
            state_q <= state_d;
            // Word two may not be taken before the source data is back
            instr_ready <= state_d != S_RET_NOP
                        && !(run_acc && op == OP_MOVE);
            mem_req <= mem_req_d;
        end
    end

    // Read data lasts one cycle; keep it in case word two is late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_q <= 1'b0;
            hold_q <= 8'h00;
            src_ind_q <= 1'b0;
            move_nop_q <= 1'b0;
        end else begin
            rd_pend_q <= mem_req.re;
            if (rd_pend_q) begin
                hold_q <= mem_rdata;
            end
            if (run_acc && op == OP_MOVE) begin
                src_ind_q <= src_ind;
            end
            if (accept && state_q == S_MOVE_DEST) begin
                move_nop_q <= dst_block;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load <= 1'b0;
            pc_load_value <= 21'h000000;
        end else begin
            pc_load <= run_acc && op == OP_SUBRET;
            if (run_acc && op == OP_SUBRET) begin
                pc_load_value <= stack_top_value;
            end
        end
    end

    // -----------------------------------------------------------------
    // APB slave: one wait state, pready registered
    // -----------------------------------------------------------------
    wire apb_acc = psel && penable && !pready;
    wire apb_done = psel && penable && pready;
    wire apb_wr = apb_done && pwrite;
    wire hit_ctrl = paddr == `REG_CTRL;
    wire hit_fp = paddr == `REG_FRAME_PTR;
    wire hit_p0 = paddr == `REG_PTR0;
    wire hit_p1 = paddr == `REG_PTR1;
    wire hit_bank = paddr == `REG_BANK;
    wire hit_stat = paddr == `REG_STATUS;
    wire mapped = hit_ctrl || hit_fp || hit_p0 || hit_p1
               || hit_bank || hit_stat;
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h00000000, ext_en_q} :
        hit_fp ? {20'h00000, frame_ptr} :
        hit_p0 ? {20'h00000, ptr[0]} :
        hit_p1 ? {20'h00000, ptr[1]} :
        hit_bank ? {28'h0000000, bank_q} :
        hit_stat ? {28'h0000000, move_nop_q, src_ind_q, state_q} :
        32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_acc;
            prdata <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
            pslverr <= apb_acc && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_en_q <= `CTRL_RESET;
            bank_q <= `BANK_RESET;
        end else if (apb_wr) begin
            if (hit_ctrl) begin
                ext_en_q <= pwdata[`CTRL_EXT_BIT];
            end
            if (hit_bank) begin
                bank_q <= pwdata[3:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    wire push_go = run_acc && op == OP_PUSH;
    wire move_go = run_acc && op == OP_MOVE;
    wire ret_go = run_acc && op == OP_SUBRET;
    wire sub_go = run_acc && op == OP_SUB;
    wire move_fin = accept && state_q == S_MOVE_DEST;

    property p_push_store;
        @(posedge pclk) disable iff (!presetn)
        push_go |=> mem_req.we && mem_req.addr == $past(frame_ptr)
                 && mem_req.wdata == $past(instr_word[7:0])
                 && frame_ptr == $past(frame_ptr) - 12'h001;
    endproperty
    a_push_store: assert property (p_push_store)
        else $error("push did not store and decrement");

    property p_sub_ptr;
        @(posedge pclk) disable iff (!presetn)
        sub_go |=> ptr[$past(sub_sel)]
                   == $past(ptr[sub_sel]) - $past(k6);
    endproperty
    a_sub_ptr: assert property (p_sub_ptr)
        else $error("pointer subtract wrong");

    sequence s_ret_load;
        pc_load && !instr_ready
            && pc_load_value == $past(stack_top_value);
    endsequence
    sequence s_ret_resume;
        !pc_load && instr_ready;
    endsequence
    property p_subret;
        @(posedge pclk) disable iff (!presetn)
        ret_go |=> s_ret_load ##1 s_ret_resume;
    endproperty
    a_subret: assert property (p_subret)
        else $error("subtract and return sequence wrong");

    property p_subret_fp;
        @(posedge pclk) disable iff (!presetn)
        ret_go |=> frame_ptr == $past(frame_ptr) - $past(k6);
    endproperty
    a_subret_fp: assert property (p_subret_fp)
        else $error("frame pointer not reduced on return");

    sequence s_src_read;
        mem_req.re && state_q == S_MOVE_DEST && mem_req.addr
            == $past(frame_ptr) + {5'h00, $past(instr_word[6:0])};
    endsequence
    property p_move_src;
        @(posedge pclk) disable iff (!presetn)
        move_go && !src_ind |=> s_src_read ##1 rd_pend_q;
    endproperty
    a_move_src: assert property (p_move_src)
        else $error("move source read missing");

    property p_move_wait;
        @(posedge pclk) disable iff (!presetn)
        move_go |=> !instr_ready ##1 instr_ready;
    endproperty
    a_move_wait: assert property (p_move_wait)
        else $error("second move word not held off");

    property p_move_guard;
        @(posedge pclk) disable iff (!presetn)
        move_fin && dst_block |=> !mem_req.we;
    endproperty
    a_move_guard: assert property (p_move_guard)
        else $error("move wrote a guarded register");

    property p_move_zero;
        @(posedge pclk) disable iff (!presetn)
        move_fin && src_ind_q && !dst_block
            |=> mem_req.we && mem_req.wdata == 8'h00;
    endproperty
    a_move_zero: assert property (p_move_zero)
        else $error("indirect source did not read as zero");

    property p_move_nop;
        @(posedge pclk) disable iff (!presetn)
        move_fin && is_indirect(off_addr) |=> !mem_req.we && move_nop_q;
    endproperty
    a_move_nop: assert property (p_move_nop)
        else $error("indirect destination was written");

    property p_ext_off;
        @(posedge pclk) disable iff (!presetn)
        in_run && !ext_en_q && accept |=> !mem_req.we && !pc_load;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("extended opcode ran while disabled");
endmodule : ext_stack_decode

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import ext_decode_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0;
    logic instr_ready;
    mem_req_t mem_req;
    logic [7:0] mem_rdata = 8'h00;
    logic [20:0] stack_top_value = 21'h0;
    logic pc_load;
    logic [20:0] pc_load_value;
    std_operand_t std_op = '0;
    std_target_t std_target;
    logic [11:0] fp;
    logic [31:0] rdv;
    logic errv;
    int num_errors = 0;
    int num_checks = 0;

    ext_stack_decode dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid,
        .instr_word, .instr_ready, .mem_req, .mem_rdata,
        .stack_top_value, .pc_load, .pc_load_value, .std_op, .std_target);

    always #25 pclk = ~pclk;

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task print_verdict;
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time,
                seen, exp);
        end
    endtask : chk

    // Hung handshakes end the run here rather than at the sim limit
    task hang_guard(inout int n);
        n++;
        if (n > 20) begin
            num_errors++;
            print_verdict();
        end
    endtask : hang_guard

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            hang_guard(n);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task reg_chk(input logic [7:0] a, input logic [31:0] e,
                 input logic e_err);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
        chk(errv, e_err);
    endtask : reg_chk

    // Returns 1 ns after the accepting edge, where answers stand
    task send(input logic [15:0] w, input logic [7:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr_word <= w;
        mem_rdata <= rd;
        #1;
        while (instr_ready !== 1'b1) begin
            hang_guard(n);
            @(posedge pclk);
            #1;
        end
        @(posedge pclk);
        instr_valid <= 1'b0;
        #1;
    endtask : send

    task std_chk(input logic [7:0] f, input logic a, input logic d,
                 input logic [11:0] e);
        @(posedge pclk);
        std_op <= '{1'b1, f, a, d};
        @(posedge pclk);
        std_op <= '0;
        #1;
        chk(std_target.valid, 1'b1);
        chk(std_target.addr, e);
        chk(std_target.to_wreg, !d);
    endtask : std_chk

    task move(input logic [6:0] zs, input logic [6:0] zd,
              input logic [7:0] rd, input logic s_ind, input logic d_ok);
        send(16'hEB80 | zs, 8'h00);
        chk(mem_req.re, !s_ind);
        if (!s_ind) chk(mem_req.addr, 12'(fp + zs));
        send(16'hF000 | zd, rd);
        chk(mem_req.we, d_ok);
        if (d_ok) chk(mem_req.addr, 12'(fp + zd));
        if (d_ok) chk(mem_req.wdata, s_ind ? 8'h00 : rd);
    endtask : move

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_regs;
        reg_chk(8'h00, 32'h1, 1'b0);
        reg_chk(8'h14, 32'h0, 1'b0);
        reg_chk(8'h18, 32'h0, 1'b1);
        apb(1'b1, 8'h04, 32'h0000_0FFF);
        reg_chk(8'h04, 32'h0, 1'b0);
        apb(1'b1, 8'h10, 32'h0000_0005);
        reg_chk(8'h10, 32'h5, 1'b0);
    endtask : t_regs

    task t_push_ret;
        send(16'hEAA5, 8'h00);
        chk({mem_req.we, mem_req.addr, mem_req.wdata}, 21'h1_000A5);
        send(16'hEA00, 8'h00);
        chk({mem_req.we, mem_req.addr, mem_req.wdata}, 21'h1_FFF00);
        reg_chk(8'h04, 32'hFFE, 1'b0);
        @(posedge pclk);
        stack_top_value <= 21'h1ABCDE;
        send(16'hE9DE, 8'h00);
        chk(pc_load, 1'b1);
        chk(pc_load_value, 21'h1ABCDE);
        chk(instr_ready, 1'b0);
        @(posedge pclk);
        #1;
        chk(instr_ready, 1'b1);
        reg_chk(8'h04, 32'hFE0, 1'b0);
    endtask : t_push_ret

    task t_sub;
        send(16'hE93F, 8'h00);
        send(16'hE941, 8'h00);
        send(16'hE9A0, 8'h00);
        reg_chk(8'h08, 32'hFC1, 1'b0);
        reg_chk(8'h0C, 32'hFFF, 1'b0);
        reg_chk(8'h04, 32'hFC0, 1'b0);
        fp = 12'hFC0;
    endtask : t_sub

    task t_moves;
        static logic [6:0] bad [4] = '{7'h39, 7'h3D, 7'h3E, 7'h3F};
        move(7'h05, 7'h06, 8'h33, 1'b0, 1'b1);
        move(7'h1B, 7'h06, 8'h5A, 1'b1, 1'b1);
        reg_chk(8'h14, 32'h4, 1'b0);
        move(7'h05, 7'h23, 8'h77, 1'b0, 1'b0);
        reg_chk(8'h14, 32'h8, 1'b0);
        foreach (bad[i]) move(7'h05, bad[i], 8'h11, 1'b0, 1'b0);
        move(7'h7F, 7'h7F, 8'hC3, 1'b0, 1'b1);
        std_chk(8'h10, 1'b0, 1'b0, 12'hFD0);
        std_chk(8'h5F, 1'b0, 1'b1, 12'h01F);
    endtask : t_moves

    task t_ext_off;
        apb(1'b1, 8'h00, 32'h0);
        std_chk(8'h10, 1'b0, 1'b1, 12'h010);
        std_chk(8'hA0, 1'b0, 1'b1, 12'hFA0);
        send(16'hEA55, 8'h00);
        chk(mem_req.we, 1'b0);
        reg_chk(8'h04, 32'hFC0, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
    endtask : t_ext_off

    task t_map;
        std_chk(8'h10, 1'b0, 1'b1, 12'h010);
        std_chk(8'h60, 1'b0, 1'b0, 12'hF60);
        std_chk(8'h22, 1'b1, 1'b0, 12'h522);
    endtask : t_map

    initial begin
        fp = 12'h000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(instr_ready, 1'b1);
        chk(mem_req, 22'h0);
        t_regs();
        t_map();
        t_push_ret();
        t_sub();
        t_moves();
        t_ext_off();
        print_verdict();
    end
endmodule : testbench
